// [fse_cfg.svh]
`ifndef FSE_CFG_SVH
`define FSE_CFG_SVH
// ****************************************
// Register offsets and field positions
// ****************************************
`define FSE_OFF_CNFG 32'h0000_0004
`define FSE_OFF_ERRCNFG 32'h0000_0005
`define FSE_OFF_STAT 32'h0000_0006
`define FSE_OFF_ERRSTAT 32'h0000_0007
`define FSE_ADDR_CNFG 12'h010
`define FSE_ADDR_ERRCNFG 12'h014
`define FSE_ADDR_STAT 12'h018
`define FSE_ADDR_ERRSTAT 12'h01C
`define FSE_BIT_CMD_COMPLETE_IRQ_EN 7
`define FSE_BIT_IGNORE_SINGLE_FAULT 4
`define FSE_BIT_FORCE_DOUBLE_FAULT 1
`define FSE_BIT_FORCE_SINGLE_FAULT 0
`define FSE_BIT_DFIE 1
`define FSE_BIT_SFIE 0
`define FSE_BIT_CC 7
`define FSE_BIT_AE 5
`define FSE_BIT_PV 4
`define FSE_BIT_BUSY 3
`define FSE_BIT_DF 1
`define FSE_BIT_SF 0
`define FSE_CNFG_MASK 8'h93
`define FSE_ERRCNFG_MASK 8'h03
// ****************************************
// Reset values
// ****************************************
`define FSE_RST_CNFG 8'h00
`define FSE_RST_ERRCNFG 8'h00
`define FSE_RST_COMPLETION_ERROR_STATUS 2'b00
`define FSE_BOOT_ERR_CODE 2'b01
`endif

// [fse_pkg.sv]
package fse_pkg;
   typedef enum logic [1:0] {
      FSE_IDLE = 2'b00,
      FSE_BUSY = 2'b01
   } fse_cmd_state_t;
   typedef logic [7:0] fse_byte_t;
endpackage

// [fse_w1c_if.sv]
`timescale 1ns/10ps
interface fse_w1c_if;
   logic set;
   logic clr;
   logic flag;
   modport owner (input set, input clr, output flag);
   modport user (output set, output clr, input flag);
endinterface

// [fse_w1c_flag.sv]
`timescale 1ns/10ps
module fse_w1c_flag (
   input wire logic clock_i,
   input wire logic rst_n_i,
   fse_w1c_if.owner port
);
   logic flag_q;
   // A set in the cycle of a clear wins, so no event is lost.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flag_q <= 1'b0;
      end else if (port.set) begin
         flag_q <= 1'b1;
      end else if (port.clr) begin
         flag_q <= 1'b0;
      end
   end
   assign port.flag = flag_q;
endmodule // fse_w1c_flag

// [fse_regs.sv]
`timescale 1ns/10ps
`include "fse_cfg.svh"
// How it works
// R1: Double fault flag and enable raise interrupt.
// R2: Single fault flag and enable raise interrupt.
// R3: Error configuration bits readable and writable.
// R4: Writing one launches command, clearing complete.
// R5: Access error set on violation; blocks launch.
// R6: Protection violation set on protected program.
// R7: Protection violation blocks launch and sequences.
// R8: Busy bit high while command executes.
// R9: Status bit two reads zero.
// R10: Completion status reports command or reset errors.
// R11: Only complete, access, protection bits writable.
// R12: Double fault set on fault or busy read.
// R13: Double fault cleared by writing one.
// R14: Single fault set unless ignore bit set.
// R15: Single fault cleared by writing one.
// R16: Complete flag with enable raises interrupt.
// R17: Force double fault sets flag on reads.
// R18: Force single fault sets flag on reads.
// R19: Reset shows complete set, other flags clear.
module fse_regs #(
   parameter int ADDR_W = 12,
   parameter int DATA_W = 32,
   parameter int REG_W = 8
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [DATA_W-1:0] pwdata_i,
   output logic [DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic cmd_done_i,
   input wire logic seq_violation_i,
   input wire logic illegal_cmd_i,
   input wire logic protect_hit_i,
   input wire logic cmd_error_i,
   input wire logic [1:0] completion_code_i,
   input wire logic reset_seq_error_i,
   input wire logic array_read_i,
   input wire logic ecc_double_i,
   input wire logic ecc_single_i,
   input wire logic read_busy_block_i,
   output logic cmd_launch_o,
   output logic seq_allowed_o,
   output logic cmd_complete_irq_o,
   output logic fault_irq_o
);
   // ****************************************
   // Bus decode
   // ****************************************
   logic wr_en;
   logic rd_en;
   logic hit;
   logic setup_ph;
   logic access_ph;
   logic setup_q;
   logic sel_cnfg;
   logic sel_errcnfg;
   logic sel_stat;
   logic sel_errstat;
   assign setup_ph = psel_i && !penable_i;
   assign access_ph = psel_i && penable_i;
   assign sel_cnfg = (paddr_i == `FSE_ADDR_CNFG);
   assign sel_errcnfg = (paddr_i == `FSE_ADDR_ERRCNFG);
   assign sel_stat = (paddr_i == `FSE_ADDR_STAT);
   assign sel_errstat = (paddr_i == `FSE_ADDR_ERRSTAT);
   assign hit = sel_cnfg || sel_errcnfg || sel_stat || sel_errstat;

   // A write lands only in an access phase that follows its own setup cycle, so an
   // enable raised without a setup can never change a register.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         setup_q <= 1'b0;
      end else begin
         setup_q <= setup_ph;
      end
   end
   assign wr_en = access_ph && setup_q && pwrite_i && hit;
   assign rd_en = setup_ph && !pwrite_i;
   fse_pkg::fse_byte_t wdat;
   assign wdat = pwdata_i[REG_W-1:0];

   // ****************************************
   // Elaboration checks
   // ****************************************
   // The decode constants are twelve bits wide and every register is one byte wide.
   if (ADDR_W != 12) begin : g_bad_addr_w
      $error("fse_regs needs ADDR_W of 12");
   end
   if (REG_W != 8) begin : g_bad_reg_w
      $error("fse_regs needs REG_W of 8");
   end
   if (DATA_W < REG_W) begin : g_bad_data_w
      $error("fse_regs needs DATA_W of at least REG_W");
   end

   // ****************************************
   // Configuration registers
   // ****************************************
   fse_pkg::fse_byte_t cnfg_q;
   fse_pkg::fse_byte_t errcnfg_q;
   logic cnfg_wr;
   logic errcnfg_wr;
   assign cnfg_wr = wr_en && sel_cnfg;
   assign errcnfg_wr = wr_en && sel_errcnfg;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnfg_q <= `FSE_RST_CNFG;
      end else if (cnfg_wr) begin
         cnfg_q <= wdat & `FSE_CNFG_MASK;
      end
   end
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         errcnfg_q <= `FSE_RST_ERRCNFG;
      end else if (errcnfg_wr) begin
         errcnfg_q <= wdat & `FSE_ERRCNFG_MASK; // [R3]
      end
   end

   // ****************************************
   // Command status
   // ****************************************
   logic stat_wr;
   logic err_wr;
   assign stat_wr = wr_en && paddr_i == `FSE_ADDR_STAT;
   assign err_wr = wr_en && paddr_i == `FSE_ADDR_ERRSTAT;

   fse_w1c_if ae_if();
   fse_w1c_if pv_if();
   fse_w1c_if df_if();
   fse_w1c_if sf_if();

   assign ae_if.set = seq_violation_i || illegal_cmd_i; // [R5]
   assign ae_if.clr = stat_wr && wdat[`FSE_BIT_AE]; // [R5] [R11]
   assign pv_if.set = protect_hit_i; // [R6]
   assign pv_if.clr = stat_wr && wdat[`FSE_BIT_PV]; // [R7] [R11]

   fse_w1c_flag u_ae (.clock_i(clock_i), .rst_n_i(rst_n_i), .port(ae_if.owner));
   fse_w1c_flag u_pv (.clock_i(clock_i), .rst_n_i(rst_n_i), .port(pv_if.owner));

   // Launch is refused while the access or protection error flag stands or a command still runs, so a
   // second write of one cannot wipe the status of the command in flight.
   logic busy;
   logic launch;
   assign launch = stat_wr && wdat[`FSE_BIT_CC] && !ae_if.flag && !pv_if.flag && // [R4] [R5] [R7]
                   !busy;


   // ****************************************
   // Command state
   // ****************************************
   // Busy also ends on a fresh access or protection error, so a command that the
   // sequencer abandons cannot leave the controller busy for ever.
   fse_pkg::fse_cmd_state_t state_q;
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= fse_pkg::FSE_IDLE; // [R19]
      end else begin
         unique case (state_q)
            fse_pkg::FSE_IDLE: begin
               if (launch) begin
                  state_q <= fse_pkg::FSE_BUSY; // [R4]
               end
            end
            fse_pkg::FSE_BUSY: begin
               if (cmd_done_i || ae_if.set || pv_if.set) begin
                  state_q <= fse_pkg::FSE_IDLE; // [R4]
               end
            end
            default: begin
               state_q <= fse_pkg::FSE_IDLE;
            end
         endcase
      end
   end
   assign busy = (state_q == fse_pkg::FSE_BUSY); // [R8]

   // ****************************************
   // Command complete flag
   // ****************************************
   // The flag is kept apart from the busy state, so that a sequencer with extra
   // phases can keep the controller busy without touching the flag.
   logic cc_q;
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cc_q <= 1'b1; // [R19]
      end else if (busy && (cmd_done_i || ae_if.set || pv_if.set)) begin
         cc_q <= 1'b1; // [R4]
      end else if (launch) begin
         cc_q <= 1'b0; // [R4]
      end
   end

   // Completion status: reset sequence faults land here after release.
   logic [1:0] completion_error_status_q;
   logic boot_q;
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         boot_q <= 1'b1;
      end else begin
         boot_q <= 1'b0;
      end
   end

   // ****************************************
   // Reset sequence report
   // ****************************************
   // The reset-sequence error is taken once, at the first edge after release; a
   // later change on that input means nothing until the next reset.
   logic boot_err;
   assign boot_err = boot_q && reset_seq_error_i; // [R10] [R19]

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         completion_error_status_q <= `FSE_RST_COMPLETION_ERROR_STATUS;
      end else if (boot_err) begin
         completion_error_status_q <= `FSE_BOOT_ERR_CODE; // [R10] [R19]
      end else if (launch) begin
         completion_error_status_q <= 2'b00;
      end else if (busy && cmd_done_i && cmd_error_i) begin
         completion_error_status_q <= (completion_code_i == 2'b00) ? 2'b01 : completion_code_i; // [R10]
      end
   end

   // ****************************************
   // ECC fault flags
   // ****************************************
   // The ignore bit also masks forced single faults: software that ignores them
   // wants no single-fault interrupt of any origin.
   logic df_real;
   logic sf_real;
   logic df_force;
   logic sf_force;
   assign df_real = ecc_double_i || read_busy_block_i; // [R12]
   assign sf_real = ecc_single_i || read_busy_block_i; // [R14]
   assign df_force = cnfg_q[`FSE_BIT_FORCE_DOUBLE_FAULT]; // [R17]
   assign sf_force = cnfg_q[`FSE_BIT_FORCE_SINGLE_FAULT]; // [R18]
   assign df_if.set = array_read_i && (df_real || df_force); // [R12] [R17]
   assign df_if.clr = err_wr && wdat[`FSE_BIT_DF]; // [R13]
   assign sf_if.set = array_read_i && !cnfg_q[`FSE_BIT_IGNORE_SINGLE_FAULT] &&
                      (sf_real || sf_force); // [R14] [R18]
   assign sf_if.clr = err_wr && wdat[`FSE_BIT_SF]; // [R15]
   fse_w1c_flag u_df (.clock_i(clock_i), .rst_n_i(rst_n_i), .port(df_if.owner));
   fse_w1c_flag u_sf (.clock_i(clock_i), .rst_n_i(rst_n_i), .port(sf_if.owner));

   // ****************************************
   // Read data and answer
   // ****************************************
   fse_pkg::fse_byte_t stat_view;
   fse_pkg::fse_byte_t errstat_view;
   assign stat_view = {cc_q, 1'b0, ae_if.flag, pv_if.flag, busy, 1'b0,
                       completion_error_status_q}; // [R4] [R8] [R9] [R11]
   assign errstat_view = {6'b00_0000, df_if.flag, sf_if.flag}; // [R12] [R14]

   fse_pkg::fse_byte_t rmux;
   always_comb begin
      rmux = 8'h00;
      unique case (paddr_i)
         `FSE_ADDR_CNFG: rmux = cnfg_q;
         `FSE_ADDR_ERRCNFG: rmux = errcnfg_q; // [R3]
         `FSE_ADDR_STAT: rmux = stat_view; // [R8] [R9] [R11]
         `FSE_ADDR_ERRSTAT: rmux = errstat_view;
         default: rmux = 8'h00;
      endcase
   end
   // Data is captured in setup so that the access phase answers at once.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prdata_o <= {DATA_W{1'b0}};
      end else if (rd_en) begin
         prdata_o <= DATA_W'(rmux); // [R11]
      end
   end
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pready_o <= 1'b0;
      end else begin
         pready_o <= setup_ph;
      end
   end

   // An unmapped address is answered with an error rather than ignored silently.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pslverr_o <= 1'b0;
      end else begin
         pslverr_o <= setup_ph && !hit; // [R11]
      end
   end

   // ****************************************
   // Outputs to sequencer and interrupt controller
   // ****************************************
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cmd_launch_o <= 1'b0;
      end else begin
         cmd_launch_o <= launch; // [R4]
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         seq_allowed_o <= 1'b1;
      end else begin
         seq_allowed_o <= !pv_if.set && !pv_if.flag; // [R7]
      end
   end

   // ****************************************
   // Interrupt requests
   // ****************************************
   // Requests are levels that follow their flags one cycle late, except that the complete request drops with its flag at a launch; a flag set while its
   // enable is low raises the request as soon as software sets the enable.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cmd_complete_irq_o <= 1'b0;
      end else begin
         cmd_complete_irq_o <= cc_q && !launch && cnfg_q[`FSE_BIT_CMD_COMPLETE_IRQ_EN]; // [R16]
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fault_irq_o <= 1'b0;
      end else begin
         fault_irq_o <= (df_if.flag && errcnfg_q[`FSE_BIT_DFIE]) || // [R1]
                        (sf_if.flag && errcnfg_q[`FSE_BIT_SFIE]); // [R2]
      end
   end
endmodule // fse_regs

// [fse_regs_checker.sv]
`timescale 1ns/10ps
`include "fse_cfg.svh"
// ****************************************
// Bus and status output checks
// ****************************************
module fse_regs_checker (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic protect_hit_i,
   input wire logic cmd_launch_o,
   input wire logic seq_allowed_o,
   input wire logic cmd_complete_irq_o,
   input wire logic fault_irq_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   logic mapped;
   logic wr_acc;
   logic launch_wr;
   assign mapped = paddr_i inside {`FSE_ADDR_CNFG, `FSE_ADDR_ERRCNFG, `FSE_ADDR_STAT,
      `FSE_ADDR_ERRSTAT};
   assign wr_acc = psel_i && penable_i && pwrite_i;
   assign launch_wr = wr_acc && paddr_i == `FSE_ADDR_STAT && pwdata_i[`FSE_BIT_CC];
   AST_ANSWER: assert property (psel_i && !penable_i |=> pready_o && pslverr_o == !$past(mapped))
      else $error("bus answer wrong");
   AST_READY_PULSE: assert property (pready_o |=> !pready_o) else $error("ready too long");
   AST_RD_HIGH: assert property (prdata_o[31:8] == 24'h00_0000) else $error("upper bits set");
   AST_LAUNCH_SRC: assert property (cmd_launch_o |-> $past(launch_wr) || $past(launch_wr, 2))
      else $error("launch without write");
   AST_CC_DROP: assert property (cmd_launch_o |-> ##[0:2] !cmd_complete_irq_o)
      else $error("complete kept");
   AST_PV_BLOCK: assert property (protect_hit_i |-> ##[1:2] !seq_allowed_o)
      else $error("sequence still allowed");
   AST_FIRQ_OFF: assert property (wr_acc && paddr_i == `FSE_ADDR_ERRCNFG && pwdata_i[1:0] == 2'h0
      |=> ##1 !fault_irq_o) else $error("fault irq unmasked");
   AST_CCIRQ_OFF: assert property (wr_acc && paddr_i == `FSE_ADDR_CNFG && !pwdata_i[7]
      |=> ##1 !cmd_complete_irq_o) else $error("complete irq unmasked");
endmodule // fse_regs_checker

bind fse_regs fse_regs_checker i_fse_regs_checker (.clock_i, .rst_n_i, .psel_i, .penable_i,
   .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .protect_hit_i,
   .cmd_launch_o, .seq_allowed_o, .cmd_complete_irq_o, .fault_irq_o);

// [tb.sv]
`timescale 1ns/10ps
`include "fse_cfg.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb;
   logic clock_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic [31:0] prdata_o;
   logic pready_o, pslverr_o, cmd_launch_o, seq_allowed_o, cmd_complete_irq_o, fault_irq_o;
   logic cmd_done_i = 1'b0, seq_violation_i = 1'b0, illegal_cmd_i = 1'b0, protect_hit_i = 1'b0;
   logic cmd_error_i = 1'b0, reset_seq_error_i = 1'b0, array_read_i = 1'b0;
   logic ecc_double_i = 1'b0, ecc_single_i = 1'b0, read_busy_block_i = 1'b0;
   logic [1:0] completion_code_i = 2'h0;
   logic [7:0] rbyte;
   logic serr;
   int error_cnt = 0;
   int num_checks = 0;
   int launch_cnt = 0;
   // Row: config, fault enables, double, single, busy block, expected flags, expected irq.
   logic [15:0] tbl [8] = '{16'h00E5, 16'h0064, 16'h0092, 16'h00CF, 16'h10D0, 16'h0285,
      16'h0143, 16'h00C0};
   fse_regs i_fse_regs (.clock_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .cmd_done_i, .seq_violation_i,
      .illegal_cmd_i, .protect_hit_i, .cmd_error_i, .completion_code_i, .reset_seq_error_i,
      .array_read_i, .ecc_double_i, .ecc_single_i, .read_busy_block_i, .cmd_launch_o,
      .seq_allowed_o, .cmd_complete_irq_o, .fault_irq_o);
   initial forever #20 clock_i = ~clock_i;
   // The launch pulse lasts one cycle, so it is counted at every edge.
   always @(posedge clock_i) begin
      if (cmd_launch_o === 1'b1) begin
         launch_cnt++;
      end
   end
   // ****************************************
   // Bus and event tasks
   // ****************************************
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // The release edge is spent idle so the next setup never lands in the same time step.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= {24'h00_0000, d};
      @(posedge clock_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      if (pready_o !== 1'b1) begin
         error_cnt++;
         $display("BAD %0t no answer", $time);
         tally_and_finish();
      end
      rbyte = prdata_o[7:0];
      serr = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clock_i);
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      xfer(1'b0, a, 8'h00);
      `CHK(rbyte, e)
   endtask
   task automatic ev(input logic [8:0] v);
      {cmd_done_i, cmd_error_i, seq_violation_i, illegal_cmd_i, protect_hit_i, array_read_i,
         ecc_double_i, ecc_single_i, read_busy_block_i} <= v;
      @(posedge clock_i);
      {cmd_done_i, cmd_error_i, seq_violation_i, illegal_cmd_i, protect_hit_i, array_read_i,
         ecc_double_i, ecc_single_i, read_busy_block_i} <= 9'h000;
      @(posedge clock_i);
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (5) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(posedge clock_i);
      rd(`FSE_ADDR_STAT, 8'h80);
      rd(`FSE_ADDR_ERRSTAT, 8'h00);
      xfer(1'b1, `FSE_ADDR_ERRCNFG, 8'hFF);
      rd(`FSE_ADDR_ERRCNFG, 8'h03);
      xfer(1'b1, `FSE_ADDR_STAT, 8'h0C);
      rd(`FSE_ADDR_STAT, 8'h80);
      xfer(1'b0, 12'h020, 8'h00);
      `CHK(serr, 1'b1)
      foreach (tbl[i]) begin
         xfer(1'b1, `FSE_ADDR_CNFG, tbl[i][15:8]);
         xfer(1'b1, `FSE_ADDR_ERRCNFG, {6'h00, tbl[i][7:6]});
         ev({6'h01, tbl[i][5:3]});
         rd(`FSE_ADDR_ERRSTAT, {6'h00, tbl[i][2:1]});
         `CHK(fault_irq_o, tbl[i][0])
         xfer(1'b1, `FSE_ADDR_ERRSTAT, 8'h00);
         rd(`FSE_ADDR_ERRSTAT, {6'h00, tbl[i][2:1]});
         xfer(1'b1, `FSE_ADDR_ERRSTAT, 8'h03);
         rd(`FSE_ADDR_ERRSTAT, 8'h00);
      end
      xfer(1'b1, `FSE_ADDR_CNFG, 8'h80);
      rd(`FSE_ADDR_STAT, 8'h80);
      `CHK(cmd_complete_irq_o, 1'b1)
      xfer(1'b1, `FSE_ADDR_STAT, 8'h80);
      rd(`FSE_ADDR_STAT, 8'h08);
      `CHK(cmd_complete_irq_o, 1'b0)
      completion_code_i <= 2'h2;
      ev(9'h180);
      rd(`FSE_ADDR_STAT, 8'h82);
      xfer(1'b1, `FSE_ADDR_STAT, 8'h80);
      rd(`FSE_ADDR_STAT, 8'h08);
      ev(9'h100);
      rd(`FSE_ADDR_STAT, 8'h80);
      for (int k = 0; k < 2; k++) begin
         ev(k == 0 ? 9'h040 : 9'h020);
         xfer(1'b1, `FSE_ADDR_STAT, 8'h80);
         rd(`FSE_ADDR_STAT, 8'hA0);
         xfer(1'b1, `FSE_ADDR_STAT, 8'h20);
         rd(`FSE_ADDR_STAT, 8'h80);
      end
      ev(9'h010);
      xfer(1'b1, `FSE_ADDR_STAT, 8'h80);
      rd(`FSE_ADDR_STAT, 8'h90);
      `CHK(seq_allowed_o, 1'b0)
      `CHK(launch_cnt, 2)
      xfer(1'b1, `FSE_ADDR_STAT, 8'h10);
      rd(`FSE_ADDR_STAT, 8'h80);
      `CHK(seq_allowed_o, 1'b1)
      rst_n_i <= 1'b0;
      reset_seq_error_i <= 1'b1;
      repeat (5) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(posedge clock_i);
      rd(`FSE_ADDR_STAT, 8'h81);
      tally_and_finish();
   end
endmodule // tb
